//--- uart_pkg.sv
// constants, types and helper function for the line, modem control and status block
//
// Summary of operation
// - low two format bits pick 5, 6, 7 or 8 data bits, both directions
// - stop bit clear gives one stop; set gives 1.5 for 5 bits, else 2
// - parity enable appends parity on transmit and checks it on receive
// - parity sense clear is odd parity, set is even parity
// - force bit fixes parity at 1 for sense 0, at 0 for sense 1
// - break bit holds serial output low outside loopback until software clears it
// - divisor access bit redirects data addresses to the divisor latches
// - terminal ready pin is the inverse of its control bit, held high in loopback
// - send request pin is inverse of its bit unless auto flow takes it; held high in loopback
// - first legacy output has no pin; in loopback it drives ring status
// - strobe bus mode: interrupt pin floats while enable bit is 0
// - in loopback the interrupt enable bit drives carrier detect status
// - loopback bit set enables internal loopback, clear is normal
// - any-character resume restarts a flow-halted transmitter on any receive
// - prescaler bit set divides input clock by four before baud generator
// - data ready reads 1 while a received character is held
// - character arriving while holding full sets overrun, stored data kept
// - parity and framing flags belong to the character in holding
// - line low a whole frame sets break; one break character stored
// - holding empty sets on transfer to shifter, clears on host load
// - transmitter empty is 1 only with holding and shifter both empty
// - reading line status clears pending line status indication
// - baud rate is prescaled clock over 16 over the 16-bit divisor
package uart_pkg;

  // -------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA   = 8'h00; // rx/tx data, or divisor low
  localparam logic [7:0] ADDR_DIVHI  = 8'h04; // divisor high when access bit set
  localparam logic [7:0] ADDR_LINE   = 8'h0C; // line_format_control
  localparam logic [7:0] ADDR_MODEM  = 8'h10; // modem_output_control
  localparam logic [7:0] ADDR_STATUS = 8'h14; // line_status
  localparam logic [7:0] ADDR_MSTAT  = 8'h18; // modem_input_status

  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int LF_STOP  = 2;
  localparam int LF_PEN   = 3;
  localparam int LF_EVEN  = 4;
  localparam int LF_FORCE = 5;
  localparam int LF_BRK   = 6;
  localparam int LF_DIV   = 7;
  localparam int MC_DTR   = 0;
  localparam int MC_RTS   = 1;
  localparam int MC_OUT1  = 2;
  localparam int MC_OUT2  = 3;
  localparam int MC_LOOP  = 4;
  localparam int MC_XANY  = 5;
  localparam int MC_PRE   = 7;

  // -------------------------------------------------------------------
  // reset values and timing counts
  // -------------------------------------------------------------------
  localparam logic [7:0]  LINE_RESET  = 8'h00;
  localparam logic [7:0]  MODEM_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET   = 16'h0001;
  localparam logic [2:0]  PRE_SLOW    = 3'h4;  // divide by four
  localparam logic [2:0]  PRE_FAST    = 3'h1;  // divide by one
  localparam logic [4:0]  TICKS_BIT   = 5'h10; // oversample ticks per bit
  localparam logic [4:0]  TICKS_HALF  = 5'h08; // mid-bit sample point
  localparam logic [4:0]  TICKS_1P5   = 5'h18; // one and a half stop bits
  localparam logic [4:0]  TICKS_2     = 5'h1F; // two stop bits less one tick

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;

  // parity bit for a character under the current format
  function automatic logic parity_bit(input logic [7:0] d, input logic [7:0] fmt);
    logic ones;
    ones = ^d;
    if (fmt[LF_FORCE]) begin
      parity_bit = ~fmt[LF_EVEN];
    end else begin
      parity_bit = fmt[LF_EVEN] ? ones : ~ones;
    end
  endfunction

endpackage

//--- tick_divider.sv
// enable divider: one tick every divisor enables, silent for divisor zero
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int W = 16
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         en,
  input  wire logic [W-1:0] divisor,
  output var  logic         tick
);

  logic [W-1:0] cnt;
  wire          reload = (cnt <= {{(W-1){1'b0}}, 1'b1});

  // reload on terminal count; divisor change takes effect at next reload
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= en && reload && (divisor != '0);
      if (en) begin
        cnt <= reload ? divisor : cnt - 1'b1;
      end
    end
  end

endmodule // tick_divider
`default_nettype wire

//--- uart_line_modem_control_status.sv
// line format, modem control and line status block with ahb-lite register slave
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module uart_line_modem_control_status
  import uart_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        rx_in,
  output var  logic        tx_out,
  output var  logic        dtr_n,
  output var  logic        rts_n,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ri_n,
  input  wire logic        cd_n,
  input  wire logic        auto_rts_en,
  input  wire logic        auto_rts_n,
  input  wire logic        strobe_bus_mode,
  input  wire logic        irq_req,
  output var  logic        irq_out,
  output var  logic        irq_oe,
  output var  logic        xon_any_resume,
  output var  logic        line_status_pending
);

  // -------------------------------------------------------------------
  // registers and state
  // -------------------------------------------------------------------
  logic [7:0]  line_format_control;
  logic [7:0]  modem_output_control;
  logic [7:0]  div_lo;
  logic [7:0]  div_hi;
  logic [7:0]  tx_hold;
  logic        tx_hold_empty;
  logic [7:0]  tx_shift;
  logic        tx_busy;
  logic        tx_line;
  tx_state_e   tx_state;
  logic [4:0]  tx_ticks;
  logic [2:0]  tx_bit;
  logic [7:0]  rx_hold;
  logic        rx_ready;
  logic        rx_overrun;
  logic        rx_perr;
  logic        rx_ferr;
  logic        rx_brk;
  logic        brk_hold;
  rx_state_e   rx_state;
  logic [4:0]  rx_ticks;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_shift;
  logic        rx_par;
  logic        ph_write;
  logic        ph_read;
  logic [7:0]  ph_addr;

  // -------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------
  // zero wait states: every access completes in its first data phase
  wire         take     = hsel && htrans[1] && hready;
  wire  [7:0]  a_addr   = haddr[7:0];
  wire         dlab     = line_format_control[LF_DIV];
  wire         loop     = modem_output_control[MC_LOOP];
  wire         rd_data  = take && !hwrite && (a_addr == ADDR_DATA) && !dlab;
  wire         rd_stat  = take && !hwrite && (a_addr == ADDR_STATUS);
  wire         wr_data  = ph_write && (ph_addr == ADDR_DATA) && !dlab;
  wire         wr_divlo = ph_write && (ph_addr == ADDR_DATA) && dlab;
  wire         wr_divhi = ph_write && (ph_addr == ADDR_DIVHI) && dlab;
  wire         wr_line  = ph_write && (ph_addr == ADDR_LINE);
  wire         wr_modem = ph_write && (ph_addr == ADDR_MODEM);
  wire  [7:0]  wbyte    = hwdata[7:0];

  // -------------------------------------------------------------------
  // status views
  // -------------------------------------------------------------------
  // transmitter empty
  wire         tx_empty = tx_hold_empty && !tx_busy;
  // data ready, per-character errors, holding empty
  wire  [7:0]  line_status = {1'b0, tx_empty, tx_hold_empty, rx_brk, rx_ferr,
                              rx_perr, rx_overrun, rx_ready};
  // ring from first legacy output, carrier from enable bit
  wire  [3:0]  modem_lvl = loop ? {modem_output_control[MC_OUT2], modem_output_control[MC_OUT1],
                                   modem_output_control[MC_DTR], modem_output_control[MC_RTS]}
                                : {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
  wire  [7:0]  modem_input_status = {modem_lvl, 4'h0};

  logic [7:0] rd_mux;
  // read multiplexer; unmapped offsets read as zero
  always_comb begin
    rd_mux = 8'h00;
    case (a_addr)
      ADDR_DATA:   rd_mux = dlab ? div_lo : rx_hold;
      ADDR_DIVHI:  rd_mux = dlab ? div_hi : 8'h00;
      ADDR_LINE:   rd_mux = line_format_control;
      ADDR_MODEM:  rd_mux = modem_output_control;
      ADDR_STATUS: rd_mux = line_status;
      ADDR_MSTAT:  rd_mux = modem_input_status;
      default:     rd_mux = 8'h00;
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture; read data is sampled here so it stands in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write <= 1'b0;
      ph_read  <= 1'b0;
      ph_addr  <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end else begin
      ph_write <= take && hwrite;
      ph_read  <= take && !hwrite;
      if (take) begin
        ph_addr <= a_addr;
      end
      if (take && !hwrite) begin
        hrdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  // -------------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_format_control  <= LINE_RESET;
      modem_output_control <= MODEM_RESET;
      div_lo               <= DIV_RESET[7:0];
      div_hi               <= DIV_RESET[15:8];
    end else begin
      if (wr_line)  line_format_control  <= wbyte;
      // reserved bit is stored as written; host keeps it 0
      if (wr_modem) modem_output_control <= wbyte;
      if (wr_divlo) div_lo <= wbyte;
      if (wr_divhi) div_hi <= wbyte;
    end
  end

  // -------------------------------------------------------------------
  // baud generation
  // -------------------------------------------------------------------
  logic pre_tick;
  logic tick16;
  // optional divide by four ahead of the baud generator
  tick_divider #(.W(3)) u_prescale (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (1'b1),
    .divisor (modem_output_control[MC_PRE] ? PRE_SLOW : PRE_FAST),
    .tick    (pre_tick)
  );
  // divisor produces the sixteen-times bit rate enable
  tick_divider #(.W(16)) u_baud (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (pre_tick),
    .divisor ({div_hi, div_lo}),
    .tick    (tick16)
  );

  // -------------------------------------------------------------------
  // transmitter
  // -------------------------------------------------------------------
  // character length
  wire [2:0] last_bit  = {1'b1, line_format_control[1:0]};
  wire       five_bits = (line_format_control[1:0] == 2'b00);
  // stop length in ticks, less one for the counting origin
  wire [4:0] stop_end  = !line_format_control[LF_STOP] ? TICKS_BIT - 5'h01 :
                         five_bits ? TICKS_1P5 - 5'h01 : TICKS_2;
  wire [7:0] len_mask  = 8'hFF >> (3'h3 - line_format_control[1:0]);
  wire       tx_bitend = tick16 && (tx_ticks == TICKS_BIT - 5'h01);
  wire       tx_load   = (tx_state == TX_IDLE) && !tx_hold_empty && tick16;

  // holding register: a host load clears empty; a transfer to the shifter sets it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_hold       <= 8'h00;
      tx_hold_empty <= 1'b1;
    end else begin
      if (wr_data) begin
        tx_hold <= wbyte;
      end
      if (wr_data) begin
        tx_hold_empty <= 1'b0;
      end else if (tx_load) begin
        tx_hold_empty <= 1'b1;
      end
    end
  end

  // start, data lsb first, parity, stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state <= TX_IDLE;
      tx_ticks <= 5'h00;
      tx_bit   <= 3'h0;
      tx_shift <= 8'h00;
      tx_busy  <= 1'b0;
      tx_line  <= 1'b1;
    end else begin
      if (tick16) begin
        tx_ticks <= tx_ticks + 5'h01;
      end
      case (tx_state)
        TX_IDLE: begin
          tx_line <= 1'b1;
          if (tx_load) begin
            tx_shift <= tx_hold & len_mask;
            tx_busy  <= 1'b1;
            tx_ticks <= 5'h00;
            tx_line  <= 1'b0;
            tx_state <= TX_START;
          end
        end
        TX_START: begin
          if (tx_bitend) begin
            tx_ticks <= 5'h00;
            tx_bit   <= 3'h0;
            tx_line  <= tx_shift[0];
            tx_state <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bitend) begin
            tx_ticks <= 5'h00;
            tx_bit   <= tx_bit + 3'h1;
            tx_line  <= tx_shift[tx_bit + 3'h1];
            if (tx_bit == last_bit) begin
              if (line_format_control[LF_PEN]) begin
                tx_line  <= parity_bit(tx_shift, line_format_control);
                tx_state <= TX_PARITY;
              end else begin
                tx_line  <= 1'b1;
                tx_state <= TX_STOP;
              end
            end
          end
        end
        TX_PARITY: begin
          if (tx_bitend) begin
            tx_ticks <= 5'h00;
            tx_line  <= 1'b1;
            tx_state <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tick16 && (tx_ticks == stop_end)) begin
            tx_busy  <= 1'b0;
            tx_state <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // break forces the line low; loopback keeps the pin idle
  wire tx_wire = tx_line && !line_format_control[LF_BRK];
  assign tx_out = loop ? 1'b1 : tx_wire;

  // -------------------------------------------------------------------
  // receiver
  // -------------------------------------------------------------------
  // loopback feeds the transmitter straight back
  wire rx_line   = loop ? tx_wire : rx_in;
  wire rx_sample = tick16 && (rx_ticks == TICKS_BIT - 5'h01);
  wire [7:0] rx_data = rx_shift & len_mask;
  wire rx_pbad   = line_format_control[LF_PEN] &&
                   (rx_par != parity_bit(rx_data, line_format_control));
  // whole frame low: data, parity and stop all zero
  wire rx_isbrk  = (rx_data == 8'h00) && !rx_line &&
                   (!line_format_control[LF_PEN] || !rx_par);
  wire rx_done   = (rx_state == RX_STOP) && rx_sample;
  wire rx_store  = rx_done && !(rx_isbrk && brk_hold);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= RX_IDLE;
      rx_ticks <= 5'h00;
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
      rx_par   <= 1'b0;
    end else begin
      if (tick16) begin
        rx_ticks <= rx_ticks + 5'h01;
      end
      case (rx_state)
        RX_IDLE: begin
          if (!rx_line) begin
            rx_ticks <= 5'h00;
            rx_shift <= 8'h00;
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          // confirm start at mid bit, then realign to bit centres
          if (tick16 && (rx_ticks == TICKS_HALF - 5'h01)) begin
            rx_ticks <= 5'h00;
            rx_bit   <= 3'h0;
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_ticks         <= 5'h00;
            rx_shift[rx_bit] <= rx_line;
            rx_bit           <= rx_bit + 3'h1;
            if (rx_bit == last_bit) begin
              rx_state <= line_format_control[LF_PEN] ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rx_sample) begin
            rx_ticks <= 5'h00;
            rx_par   <= rx_line;
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          // only the first stop bit is checked, so back-to-back frames keep pace
          if (rx_sample) begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // holding register and its flags; new events win over read clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_hold    <= 8'h00;
      rx_ready   <= 1'b0;
      rx_overrun <= 1'b0;
      rx_perr    <= 1'b0;
      rx_ferr    <= 1'b0;
      rx_brk     <= 1'b0;
      brk_hold   <= 1'b0;
    end else begin
      // one break character per break; rearm when line idles high
      if (rx_done && rx_isbrk) begin
        brk_hold <= 1'b1;
      end else if (rx_line && (rx_state == RX_IDLE)) begin
        brk_hold <= 1'b0;
      end
      if (rx_store && rx_ready && !rd_data) begin
        rx_overrun <= 1'b1;
      end else if (rd_stat) begin
        rx_overrun <= 1'b0;
      end
      if (rx_store && (!rx_ready || rd_data)) begin
        rx_hold  <= rx_data;
        rx_ready <= 1'b1;
        rx_perr  <= rx_pbad;
        rx_ferr  <= !rx_line && !rx_isbrk;
        rx_brk   <= rx_isbrk;
      end else if (rd_data) begin
        rx_ready <= 1'b0;
        rx_perr  <= 1'b0;
        rx_ferr  <= 1'b0;
        rx_brk   <= 1'b0;
      end
    end
  end

  // pending line status indication, cleared by a status read
  wire ls_event = rx_store && (rx_ready || rx_pbad || !rx_line);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_status_pending <= 1'b0;
      xon_any_resume      <= 1'b0;
    end else begin
      if (ls_event) begin
        line_status_pending <= 1'b1;
      end else if (rd_stat) begin
        line_status_pending <= 1'b0;
      end
      // any received character resumes a halted transmitter
      xon_any_resume <= rx_done && modem_output_control[MC_XANY];
    end
  end

  // -------------------------------------------------------------------
  // modem and interrupt pins
  // -------------------------------------------------------------------
  // terminal ready inverse of its bit; idle high during loopback
  assign dtr_n   = loop ? 1'b1 : ~modem_output_control[MC_DTR];
  // send request, overridden by automatic flow control
  assign rts_n   = loop ? 1'b1 : (auto_rts_en ? auto_rts_n : ~modem_output_control[MC_RTS]);
  // strobe mode drives the pin only when enabled
  assign irq_out = irq_req;
  assign irq_oe  = strobe_bus_mode ? modem_output_control[MC_OUT2] : 1'b1;

  // hsize and the read phase flag carry no behaviour: only word access is used
  wire unused_ok = &{1'b0, hsize, ph_read, haddr[31:8]};

endmodule // uart_line_modem_control_status
`default_nettype wire

//--- uart_checker_assertions.sv
// port-level assertions for the line, modem control and status block
`timescale 1ns/100ps
`default_nettype none
module uart_checker
  import uart_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        tx_out,
  input wire logic        dtr_n,
  input wire logic        rts_n,
  input wire logic        auto_rts_en,
  input wire logic        auto_rts_n,
  input wire logic        strobe_bus_mode,
  input wire logic        irq_oe,
  input wire logic        xon_any_resume
);
  logic       wr_p, rd_p;
  logic [7:0] a_p, lf, mc;
  wire logic  take = hsel & htrans[1] & hready;
  wire logic  rd_st = rd_p && a_p == ADDR_STATUS;
  // shadow of both control registers, committed in the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_p, rd_p, a_p, lf, mc} <= '0;
    end else begin
      {wr_p, rd_p, a_p} <= {take & hwrite, take & ~hwrite, haddr[7:0]};
      if (wr_p && a_p == ADDR_LINE) lf <= hwdata[7:0];
      if (wr_p && a_p == ADDR_MODEM) mc <= hwdata[7:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_dtr_from_bit: assert property (dtr_n == (mc[MC_LOOP] | ~mc[MC_DTR]))
    else $error("dtr_n does not follow its bit");
  a_rts_from_bit: assert property (!mc[MC_LOOP] |->
    rts_n == (auto_rts_en ? auto_rts_n : ~mc[MC_RTS])) else $error("rts_n wrong");
  a_irq_pin_gate: assert property (irq_oe == (~strobe_bus_mode | mc[MC_OUT2]))
    else $error("irq_oe does not follow enable bit");
  a_break_low: assert property (lf[LF_BRK] && !mc[MC_LOOP] |-> !tx_out)
    else $error("tx_out not held low in break");
  a_loop_pin_idle: assert property (mc[MC_LOOP] |-> tx_out)
    else $error("tx_out not idle in loopback");
  a_resume_pulse: assert property (xon_any_resume |->
    $past(mc[MC_XANY]) && !$past(xon_any_resume)) else $error("resume pulse wrong");
  a_temt_thre: assert property (rd_st |-> !hrdata[6] || hrdata[5])
    else $error("transmitter empty with holding full");
  a_divhi_hidden: assert property (rd_p && a_p == ADDR_DIVHI &&
    !$past(lf[LF_DIV]) |-> hrdata == 32'h0) else $error("divisor seen in data space");
endmodule // uart_checker
bind uart_line_modem_control_status uart_checker u_uart_checker (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .tx_out, .dtr_n,
  .rts_n, .auto_rts_en, .auto_rts_n, .strobe_bus_mode, .irq_oe, .xon_any_resume);
`default_nettype wire

//--- remote_serial.sv
// remote serial end: sends frames on rx_in and captures frames from tx_out
`timescale 1ns/100ps
`default_nettype none
module remote_serial #(
  parameter int BIT_CYC = 16
) (
  input  wire logic hclk,
  input  wire logic tx_out,
  output var  logic rx_in
);
  logic [10:0] cap;
  initial rx_in = 1'b1;
  // frame bits out lsb first, line idles high
  task automatic send(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      rx_in <= f[i];
      repeat (BIT_CYC) @(posedge hclk);
    end
  endtask
  // mid-cell samples after the start edge; blind while busy
  always @(negedge tx_out) begin
    repeat (BIT_CYC / 2) @(posedge hclk);
    for (int i = 0; i < 11; i++) begin
      repeat (BIT_CYC) @(posedge hclk);
      cap[i] = tx_out;
    end
  end
endmodule // remote_serial
`default_nettype wire

//--- tb.sv
// self-checking bench for the line, modem control and status block
`timescale 1ns/100ps
`default_nettype none
module tb
  import uart_pkg::*;
;
  logic        hclk = 1'b0, hresetn, hsel, hwrite, hready, hresp, tx_out, rx_in;
  logic        dtr_n, rts_n, auto_rts_en, auto_rts_n, strobe_bus_mode, irq_out;
  logic        irq_oe, xon_any_resume, line_status_pending, irq_req;
  logic [1:0]  htrans;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0]  fmt [6] = '{8'h03, 8'h00, 8'h09, 8'h1A, 8'h2F, 8'h3F};
  logic [7:0]  dat [6] = '{8'hA5, 8'h3A, 8'h2C, 8'h35, 8'h00, 8'hFF};
  logic [7:0]  md;
  logic [10:0] e;
  int          n_fail = 0, checked = 0;
  always #4 hclk = ~hclk;
  uart_line_modem_control_status u_uart_line_modem_control_status (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready),
    .hresp, .hrdata, .rx_in, .tx_out, .dtr_n, .rts_n, .cts_n(1'b1), .dsr_n(1'b1),
    .ri_n(1'b1), .cd_n(1'b1), .auto_rts_en, .auto_rts_n, .strobe_bus_mode,
    .irq_req, .irq_out, .irq_oe, .xon_any_resume, .line_status_pending);
  remote_serial u_remote_serial (.hclk, .tx_out, .rx_in);
  task automatic chk(input logic [31:0] got, exp, input string nm);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, d);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // idle first so a read never meets a pending write
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge hclk);
    bus(1'b0, a, 8'h00);
    chk(r, exp, nm);
  endtask
  task automatic poll(input logic [31:0] m);
    r = 32'h0;
    for (int i = 0; i < 300 && (r & m) == 0; i++) bus(1'b0, ADDR_STATUS, 8'h00);
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, irq_req, auto_rts_en, auto_rts_n, strobe_bus_mode} = '0;
    {htrans, haddr, hwdata} = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ADDR_LINE, 32'h0, "line_format_control");
    rd(ADDR_MODEM, 32'h0, "modem_output_control");
    rd(ADDR_STATUS, 32'h60, "line_status");
    rd(8'h1C, 32'h0, "unmapped");
    chk(irq_oe, 1'b1, "irq_oe");
    strobe_bus_mode <= 1'b1;
    // enable bit only in strobe mode, reserved bit kept 0
    for (int i = 0; i < 2; i++) begin
      irq_req <= 1'(i);
      bus(1'b1, ADDR_MODEM, {4'h0, 1'(i), 3'h3});
      @(posedge hclk);
      chk({irq_oe, irq_out}, {2{1'(i)}}, "irq");
      chk({dtr_n, rts_n}, 2'b00, "dtr_n rts_n");
    end
    {auto_rts_en, auto_rts_n} <= 2'b11;
    repeat (2) @(posedge hclk);
    chk(rts_n, 1'b1, "rts_n auto");
    auto_rts_en <= 1'b0;
    // every length and parity mode, frame captured by the remote end
    for (int k = 0; k < 6; k++) begin
      md = dat[k] & ~(8'hFF << (5 + fmt[k][1:0]));
      e = {3'h7, md | (8'hFF << (5 + fmt[k][1:0]))};
      if (fmt[k][LF_PEN]) e[5 + fmt[k][1:0]] = fmt[k][LF_FORCE] ?
        ~fmt[k][LF_EVEN] : ~^{fmt[k][LF_EVEN], md};
      bus(1'b1, ADDR_LINE, fmt[k]);
      bus(1'b1, ADDR_DATA, dat[k]);
      rd(ADDR_STATUS, 32'h20, "line_status");
      chk(r & 32'h40, 32'h0, "busy temt");
      poll(32'h40);
      repeat (96) @(posedge hclk);
      chk(u_remote_serial.cap, e, "serial frame");
    end
    bus(1'b1, ADDR_DATA, 8'h81);
    @(posedge hclk);
    bus(1'b1, ADDR_DATA, 8'h7E);
    rd(ADDR_STATUS, 32'h0, "line_status");
    chk(r & 32'h60, 32'h0, "holding full");
    poll(32'h40);
    bus(1'b1, ADDR_LINE, 8'h43);
    repeat (2) @(posedge hclk);
    chk(tx_out, 1'b0, "tx_out break");
    bus(1'b1, ADDR_LINE, 8'h03);
    repeat (2) @(posedge hclk);
    chk(tx_out, 1'b1, "tx_out idle");
    bus(1'b1, ADDR_MODEM, 8'h20);
    u_remote_serial.send({3'h7, 8'h5A, 1'b0});
    rd(ADDR_STATUS, 32'h61, "line_status ready");
    rd(ADDR_DATA, 32'h5A, "rx data");
    u_remote_serial.send({3'h7, 8'h11, 1'b0});
    u_remote_serial.send({3'h7, 8'h22, 1'b0});
    chk(line_status_pending, 1'b1, "pending");
    rd(ADDR_STATUS, 32'h63, "line_status overrun");
    chk(line_status_pending, 1'b0, "pending");
    rd(ADDR_DATA, 32'h11, "rx data kept");
    rd(ADDR_STATUS, 32'h60, "line_status");
    bus(1'b1, ADDR_LINE, 8'h1B);
    u_remote_serial.send({3'h7, 8'h0F, 1'b0});
    rd(ADDR_STATUS, 32'h65, "line_status parity");
    rd(ADDR_DATA, 32'h0F, "rx data");
    rd(ADDR_STATUS, 32'h60, "line_status");
    bus(1'b1, ADDR_LINE, 8'h03);
    u_remote_serial.send(12'hC00);
    rd(ADDR_STATUS, 32'h71, "line_status break");
    rd(ADDR_DATA, 32'h0, "break data");
    bus(1'b1, ADDR_MODEM, 8'h10);
    bus(1'b1, ADDR_DATA, 8'hC3);
    poll(32'h01);
    rd(ADDR_DATA, 32'hC3, "loop data");
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, ADDR_MODEM, 8'h14 + 8'(i * 4));
      rd(ADDR_MSTAT, 32'h40 << i, "modem_input_status");
    end
    bus(1'b1, ADDR_LINE, 8'h83);
    bus(1'b1, ADDR_DATA, 8'h05);
    bus(1'b1, ADDR_DIVHI, 8'h01);
    rd(ADDR_DATA, 32'h05, "divisor low");
    rd(ADDR_DIVHI, 32'h01, "divisor_high_latch");
    bus(1'b1, ADDR_LINE, 8'h03);
    rd(ADDR_DIVHI, 32'h0, "data space");
    report_and_stop;
  end
  // hang guard, well past the expected run length
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
